// file: verilog/dma_ctl_defs.svh
// constants for the per-channel transfer control block
`ifndef DMA_CTL_DEFS_SVH
`define DMA_CTL_DEFS_SVH

// coprocessor register selects (opcode 1, crm, opcode 2)
`define OPC1_REG 3'h0
`define OPC1_CMD 3'h3
`define CRM_CHAN_SEL 4'h2
`define CRM_COMMAND 4'h3
`define CRM_CTRL 4'h4
`define CRM_INT_START 4'h5
`define CRM_EXT_START 4'h6
`define CRM_CHAN_STATUS 4'h8
`define OPC2_STOP 3'h0
`define OPC2_START 3'h1
`define OPC2_CLEAR 3'h2

// channel_transfer_control field positions
`define CTRL_TARGET_BIT 31
`define CTRL_DIRECTION_BIT 30
`define CTRL_IRQ_DONE_BIT 29
`define CTRL_IRQ_FAULT_BIT 28
`define CTRL_LEGACY_BIT 27
`define CTRL_UNPRIV_BIT 26
`define CTRL_STEP_HI 19
`define CTRL_STEP_LO 8
`define CTRL_SIZE_HI 1
`define CTRL_SIZE_LO 0

// writable bits and the value the register holds after reset
`define CTRL_WRITE_MASK 32'hf40f_ff03
`define CTRL_RESET 32'h0000_0000
`define CTRL_READ_ONES 32'h0800_0000

// status register fields
`define STAT_CODE_HI 2
`define STAT_FAULT_BIT 4
`define STAT_BADPARAM_BIT 5
`define STAT_IRQ_BIT 8

`define FIFO_DEPTH 8

`endif

// file: verilog/dma_ctl_pkg.sv
// types shared by the transfer control block and its access queue
package dma_ctl_pkg;

  typedef enum logic [2:0] {
    st_idle,
    st_queued,
    st_running,
    st_complete,
    st_error
  } chan_state_e;

  typedef struct packed {
    logic [31:0] ctrl;
    logic user_prog;
    logic [31:0] int_addr;
    logic [31:0] ext_addr;
    chan_state_e status;
    logic fault;
    logic bad_param;
    logic irq;
  } chan_s;

  typedef struct packed {
    logic channel;
    logic to_ext;
    logic itcm;
    logic user;
    logic [1:0] size;
    logic [31:0] int_addr;
    logic [31:0] ext_addr;
  } acc_s;

endpackage

// file: verilog/access_fifo.sv
// flop based first-in first-out queue with valid and ready on both sides
`timescale 1ns/10ps
module access_fifo #(
  parameter int WIDTH = 70,
  parameter int DEPTH = 8
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
  } fifo_s;

  fifo_s state_reg;
  fifo_s state_next;
  logic push;
  logic pop;

  assign in_ready = state_reg.count != (AW+1)'(DEPTH);
  assign out_valid = state_reg.count != '0;
  assign out_data = state_reg.mem[state_reg.rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    state_next = state_reg;
    if (push) begin
      state_next.mem[state_reg.wr_ptr] = in_data;
      if (state_reg.wr_ptr == AW'(DEPTH - 1)) begin
        state_next.wr_ptr = '0;
      end else begin
        state_next.wr_ptr = state_reg.wr_ptr + AW'(1);
      end
    end
    if (pop) begin
      if (state_reg.rd_ptr == AW'(DEPTH - 1)) begin
        state_next.rd_ptr = '0;
      end else begin
        state_next.rd_ptr = state_reg.rd_ptr + AW'(1);
      end
    end
    if (push && !pop) begin
      state_next.count = state_reg.count + (AW+1)'(1);
    end else if (pop && !push) begin
      state_next.count = state_reg.count - (AW+1)'(1);
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end
endmodule // access_fifo

// file: verilog/tcm_dma_channel_control.sv
// two channel level one transfer engine: control registers, commands, access issue
//
// How it works
// - each channel owns a 32-bit control register
// - bit 31 picks data or instruction memory
// - bit 30 sets transfer direction
// - bit 29 enables interrupt on done/stop
// - clear command drops the done interrupt
// - bit 28 enables interrupt on fault
// - user channel always interrupts on fault
// - clear to idle drops the fault interrupt
// - bit 27 reads one, writes ignored
// - bit 26 selects user or privileged checks
// - user-mode programming forces user accesses, bit 26 unchanged
// - bits 19:8 give external byte step
// - step is unsigned, never negative
// - zero step holds the external address
// - internal address advances by access size
// - misaligned step gives bad-parameter fault
// - bits 1:0 encode byte to doubleword
// - every access issued at programmed size
// - control writes ignored while running/queued
// - clear moves done/fault to idle, wipes errors
// - channel select bit picks channel register set
`timescale 1ns/10ps
`include "dma_ctl_defs.svh"
module tcm_dma_channel_control (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic cp_valid,
  input wire logic cp_write,
  input wire logic [2:0] cp_opc1,
  input wire logic [3:0] cp_crm,
  input wire logic [2:0] cp_opc2,
  input wire logic [31:0] cp_wdata,
  input wire logic cp_user_mode,
  output logic [31:0] cp_rdata,
  input wire logic [1:0] chan_user_bit,
  output logic acc_valid,
  input wire logic acc_ready,
  output logic acc_channel,
  output logic acc_to_ext,
  output logic acc_itcm,
  output logic acc_user,
  output logic [1:0] acc_size,
  output logic [31:0] acc_int_addr,
  output logic [31:0] acc_ext_addr,
  input wire logic mem_done,
  input wire logic mem_fault,
  output logic [1:0] dma_irq
);

  typedef struct packed {
    logic channel_select;
    logic [31:0] rdata;
    dma_ctl_pkg::chan_s [1:0] ch;
  } ctl_s;

  ctl_s state_reg;
  ctl_s state_next;
  dma_ctl_pkg::acc_s push_entry;
  dma_ctl_pkg::acc_s head_entry;
  logic push_valid;
  logic push_ready;

  // channel counts as busy for the other one while queued, running or faulted
  function automatic logic in_operation(input dma_ctl_pkg::chan_s c);
    in_operation = (c.status == dma_ctl_pkg::st_queued) ||
                   (c.status == dma_ctl_pkg::st_running) ||
                   (c.status == dma_ctl_pkg::st_error);
  endfunction

  // step must be a multiple of the access size
  function automatic logic step_misaligned(input logic [31:0] ctrl);
    logic [11:0] step;
    step = ctrl[`CTRL_STEP_HI:`CTRL_STEP_LO];
    case (ctrl[`CTRL_SIZE_HI:`CTRL_SIZE_LO])
      2'h0: step_misaligned = 1'b0;
      2'h1: step_misaligned = step[0];
      2'h2: step_misaligned = |step[1:0];
      default: step_misaligned = |step[2:0];
    endcase
  endfunction

  // fault interrupt enable, forced on for user-accessible channels
  function automatic logic fault_irq_on(input logic [31:0] ctrl, input logic ubit);
    fault_irq_on = ctrl[`CTRL_IRQ_FAULT_BIT] | ubit;
  endfunction

  function automatic logic [31:0] status_word(input dma_ctl_pkg::chan_s c);
    logic [31:0] w;
    w = '0;
    w[`STAT_CODE_HI:0] = c.status;
    w[`STAT_FAULT_BIT] = c.fault;
    w[`STAT_BADPARAM_BIT] = c.bad_param;
    w[`STAT_IRQ_BIT] = c.irq;
    status_word = w;
  endfunction

  always_comb begin
    logic sel;
    logic other;
    logic is_reg;
    dma_ctl_pkg::chan_s c;
    state_next = state_reg;
    push_valid = 1'b0;
    push_entry = '0;
    sel = state_reg.channel_select;
    other = ~sel;
    is_reg = cp_opc1 == `OPC1_REG;
    c = state_reg.ch[sel];

    // processor writes and commands
    if (cp_valid && cp_write) begin
      if (is_reg && cp_crm == `CRM_CHAN_SEL) begin
        state_next.channel_select = cp_wdata[0];
      end else if (is_reg && cp_crm == `CRM_CTRL) begin
        if (c.status != dma_ctl_pkg::st_running &&
            c.status != dma_ctl_pkg::st_queued) begin
          state_next.ch[sel].ctrl = cp_wdata & `CTRL_WRITE_MASK;
          state_next.ch[sel].user_prog = cp_user_mode;
        end
      end else if (is_reg && cp_crm == `CRM_INT_START) begin
        if (c.status != dma_ctl_pkg::st_running &&
            c.status != dma_ctl_pkg::st_queued) begin
          state_next.ch[sel].int_addr = cp_wdata;
        end
      end else if (is_reg && cp_crm == `CRM_EXT_START) begin
        if (c.status != dma_ctl_pkg::st_running &&
            c.status != dma_ctl_pkg::st_queued) begin
          state_next.ch[sel].ext_addr = cp_wdata;
        end
      end else if (cp_opc1 == `OPC1_CMD && cp_crm == `CRM_COMMAND) begin
        case (cp_opc2)
          `OPC2_STOP: begin
            if (c.status == dma_ctl_pkg::st_running) begin
              state_next.ch[sel].status = dma_ctl_pkg::st_complete;
              state_next.ch[sel].irq = c.irq | c.ctrl[`CTRL_IRQ_DONE_BIT];
            end else if (c.status == dma_ctl_pkg::st_queued) begin
              state_next.ch[sel].status = dma_ctl_pkg::st_idle;
            end
          end
          `OPC2_START: begin
            if (c.status == dma_ctl_pkg::st_idle) begin
              if (step_misaligned(c.ctrl)) begin
                state_next.ch[sel].status = dma_ctl_pkg::st_error;
                state_next.ch[sel].bad_param = 1'b1;
                state_next.ch[sel].irq = c.irq | fault_irq_on(c.ctrl, chan_user_bit[sel]);
              end else if (in_operation(state_reg.ch[other])) begin
                state_next.ch[sel].status = dma_ctl_pkg::st_queued;
              end else begin
                state_next.ch[sel].status = dma_ctl_pkg::st_running;
              end
            end
          end
          `OPC2_CLEAR: begin
            if (c.status == dma_ctl_pkg::st_complete ||
                c.status == dma_ctl_pkg::st_error) begin
              state_next.ch[sel].status = dma_ctl_pkg::st_idle;
              state_next.ch[sel].fault = 1'b0;
              state_next.ch[sel].bad_param = 1'b0;
              state_next.ch[sel].irq = 1'b0;
            end
          end
          default: begin
          end
        endcase
      end
    end

    // register reads, answered one cycle later
    if (cp_valid && !cp_write) begin
      if (is_reg && cp_crm == `CRM_CHAN_SEL) begin
        state_next.rdata = {31'h0, sel};
      end else if (is_reg && cp_crm == `CRM_CTRL) begin
        state_next.rdata = (c.ctrl & `CTRL_WRITE_MASK) | `CTRL_READ_ONES;
      end else if (is_reg && cp_crm == `CRM_INT_START) begin
        state_next.rdata = c.int_addr;
      end else if (is_reg && cp_crm == `CRM_EXT_START) begin
        state_next.rdata = c.ext_addr;
      end else if (is_reg && cp_crm == `CRM_CHAN_STATUS) begin
        state_next.rdata = status_word(c);
      end else begin
        state_next.rdata = '0;
      end
    end

    // access issue for the running channel
    for (int i = 0; i < 2; i++) begin
      if (state_next.ch[i].status == dma_ctl_pkg::st_running) begin
        if (mem_fault) begin
          state_next.ch[i].status = dma_ctl_pkg::st_error;
          state_next.ch[i].fault = 1'b1;
          state_next.ch[i].irq = state_reg.ch[i].irq |
                                 fault_irq_on(state_reg.ch[i].ctrl, chan_user_bit[i]);
        end else if (mem_done) begin
          state_next.ch[i].status = dma_ctl_pkg::st_complete;
          state_next.ch[i].irq = state_reg.ch[i].irq |
                                 state_reg.ch[i].ctrl[`CTRL_IRQ_DONE_BIT];
        end else begin
          push_valid = 1'b1;
          push_entry.channel = 1'(i);
          push_entry.itcm = state_reg.ch[i].ctrl[`CTRL_TARGET_BIT];
          push_entry.to_ext = state_reg.ch[i].ctrl[`CTRL_DIRECTION_BIT];
          push_entry.user = state_reg.ch[i].ctrl[`CTRL_UNPRIV_BIT] |
                            state_reg.ch[i].user_prog;
          push_entry.size = state_reg.ch[i].ctrl[`CTRL_SIZE_HI:`CTRL_SIZE_LO];
          push_entry.int_addr = state_reg.ch[i].int_addr;
          push_entry.ext_addr = state_reg.ch[i].ext_addr;
          if (push_ready) begin
            state_next.ch[i].int_addr = state_reg.ch[i].int_addr +
                                        (32'h0000_0001 << push_entry.size);
            state_next.ch[i].ext_addr = state_reg.ch[i].ext_addr +
                                        {20'h0_0000,
                                         state_reg.ch[i].ctrl[`CTRL_STEP_HI:`CTRL_STEP_LO]};
          end
        end
      end
    end

    // a queued channel runs once the other leaves operation
    for (int i = 0; i < 2; i++) begin
      if (state_next.ch[i].status == dma_ctl_pkg::st_queued &&
          !in_operation(state_next.ch[1-i]) &&
          state_next.ch[1-i].status != dma_ctl_pkg::st_running) begin
        state_next.ch[i].status = dma_ctl_pkg::st_running;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  access_fifo #(
    .WIDTH($bits(dma_ctl_pkg::acc_s)),
    .DEPTH(`FIFO_DEPTH)
  ) u_access_fifo (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .in_data(push_entry),
    .out_valid(acc_valid),
    .out_ready(acc_ready),
    .out_data(head_entry)
  );

  assign acc_channel = head_entry.channel;
  assign acc_to_ext = head_entry.to_ext;
  assign acc_itcm = head_entry.itcm;
  assign acc_user = head_entry.user;
  assign acc_size = head_entry.size;
  assign acc_int_addr = head_entry.int_addr;
  assign acc_ext_addr = head_entry.ext_addr;
  assign cp_rdata = state_reg.rdata;
  assign dma_irq = {state_reg.ch[1].irq, state_reg.ch[0].irq};

endmodule // tcm_dma_channel_control

// file: sim/tcm_dma_channel_control_monitor.sv
// concurrent checks on the channel control block ports
`timescale 1ns/10ps
module dma_ctl_monitor (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic cp_valid,
  input wire logic cp_write,
  input wire logic [2:0] cp_opc1,
  input wire logic [3:0] cp_crm,
  input wire logic [2:0] cp_opc2,
  input wire logic [31:0] cp_wdata,
  input wire logic cp_user_mode,
  input wire logic [31:0] cp_rdata,
  input wire logic [1:0] chan_user_bit,
  input wire logic acc_valid,
  input wire logic acc_ready,
  input wire logic acc_channel,
  input wire logic acc_to_ext,
  input wire logic acc_itcm,
  input wire logic acc_user,
  input wire logic [1:0] acc_size,
  input wire logic [31:0] acc_int_addr,
  input wire logic [31:0] acc_ext_addr,
  input wire logic mem_done,
  input wire logic mem_fault,
  input wire logic [1:0] dma_irq
);
  logic sel_reg;
  logic rd_any;
  logic pop;
  logic clr;
  assign rd_any = cp_valid && !cp_write && cp_opc1 == 3'h0;
  assign pop = acc_valid && acc_ready;
  assign clr = cp_valid && cp_write && cp_opc1 == 3'h3 && cp_crm == 4'h3 && cp_opc2 == 3'h2;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sel_reg <= 1'h0;
    end else if (cp_valid && cp_write && cp_opc1 == 3'h0 && cp_crm == 4'h2) begin
      sel_reg <= cp_wdata[0];
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  chk_ctrl_fixed_bits: assert property (
    rd_any && cp_crm == 4'h4 |=> cp_rdata[27] && cp_rdata[25:20] == 6'h00 && cp_rdata[7:2] == 6'h00)
    else $error("control fixed bits wrong");
  chk_unmapped_read: assert property (
    rd_any && cp_crm == 4'h7 |=> cp_rdata == 32'h0)
    else $error("unmapped read not zero");
  chk_rdata_hold: assert property (
    !(cp_valid && !cp_write) |=> $stable(cp_rdata))
    else $error("read data moved");
  chk_int_step: assert property (
    pop ##1 acc_valid && acc_channel == $past(acc_channel)
    |-> acc_int_addr == $past(acc_int_addr) + (32'h1 << acc_size))
    else $error("internal step wrong");
  chk_issue_size: assert property (
    pop ##1 acc_valid && acc_channel == $past(acc_channel)
    |-> $stable({acc_size, acc_itcm, acc_to_ext, acc_user}))
    else $error("access attributes changed");
  chk_head_hold: assert property (
    acc_valid && !acc_ready |=> acc_valid && $stable(acc_int_addr) && $stable(acc_ext_addr))
    else $error("stalled head moved");
  chk_irq_clear: assert property (
    clr && dma_irq[sel_reg] |=> (!dma_irq[sel_reg]) [*2])
    else $error("clear left interrupt set");
  chk_irq_cause: assert property (
    $rose(dma_irq[0]) || $rose(dma_irq[1])
    |-> $past(cp_valid || mem_done || mem_fault) || $past(cp_valid || mem_done || mem_fault, 2))
    else $error("interrupt without cause");
endmodule // dma_ctl_monitor

bind tcm_dma_channel_control dma_ctl_monitor dma_ctl_monitor_i (
  .clk_sys, .arst_n, .cp_valid, .cp_write, .cp_opc1, .cp_crm, .cp_opc2, .cp_wdata,
  .cp_user_mode, .cp_rdata, .chan_user_bit, .acc_valid, .acc_ready, .acc_channel,
  .acc_to_ext, .acc_itcm, .acc_user, .acc_size, .acc_int_addr, .acc_ext_addr,
  .mem_done, .mem_fault, .dma_irq);

// file: sim/mem_partner.sv
// memory side model: takes queued accesses, reports done and fault
`timescale 1ns/10ps
module mem_partner (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic acc_valid,
  output logic acc_ready,
  input wire logic [31:0] acc_int_addr,
  input wire logic [31:0] end_addr,
  input wire logic stall,
  input wire logic fault_now,
  output logic mem_done,
  output logic mem_fault
);
  logic pop;
  assign acc_ready = !stall;
  assign pop = acc_valid && !stall;
  // done when the last address of the run is taken
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      mem_done <= 1'h0;
      mem_fault <= 1'h0;
    end else begin
      mem_fault <= pop && fault_now;
      mem_done <= pop && !fault_now && acc_int_addr == end_addr;
    end
  end
endmodule // mem_partner

// file: sim/tcm_dma_channel_control_tb_top.sv
// self-checking bench for the channel control block
`timescale 1ns/10ps
module tcm_dma_channel_control_tb_top;
  logic clk_sys, arst_n, cp_valid, cp_write, cp_user_mode, stall, fault_now;
  logic [2:0] cp_opc1, cp_opc2;
  logic [3:0] cp_crm;
  logic [31:0] cp_wdata, cp_rdata, acc_int_addr, acc_ext_addr, end_addr, rd;
  logic [1:0] chan_user_bit, acc_size, dma_irq;
  logic acc_valid, acc_ready, acc_channel, acc_to_ext, acc_itcm, acc_user, mem_done, mem_fault;
  dma_ctl_pkg::acc_s got[$];
  int bad_count, total_checks;
  tcm_dma_channel_control tcm_dma_channel_control_i (
    .clk_sys, .arst_n, .cp_valid, .cp_write, .cp_opc1, .cp_crm, .cp_opc2, .cp_wdata,
    .cp_user_mode, .cp_rdata, .chan_user_bit, .acc_valid, .acc_ready, .acc_channel,
    .acc_to_ext, .acc_itcm, .acc_user, .acc_size, .acc_int_addr, .acc_ext_addr,
    .mem_done, .mem_fault, .dma_irq);
  mem_partner mem_partner_i (.clk_sys, .arst_n, .acc_valid, .acc_ready, .acc_int_addr,
    .end_addr, .stall, .fault_now, .mem_done, .mem_fault);
  initial begin
    clk_sys = 1'h0;
    forever #50 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (arst_n === 1'h1 && acc_valid === 1'h1 && acc_ready === 1'h1) begin
      got.push_back({acc_channel, acc_to_ext, acc_itcm, acc_user, acc_size, acc_int_addr,
        acc_ext_addr});
    end
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic cp(input logic w, input logic [2:0] o1, input logic [3:0] m,
    input logic [2:0] o2, input logic [31:0] d, input logic u);
    @(posedge clk_sys);
    cp_valid <= 1'h1;
    cp_write <= w;
    cp_opc1 <= o1;
    cp_crm <= m;
    cp_opc2 <= o2;
    cp_wdata <= d;
    cp_user_mode <= u;
    @(posedge clk_sys);
    cp_valid <= 1'h0;
    @(posedge clk_sys);
    #1 rd = cp_rdata;
  endtask
  task automatic wr(input logic [3:0] m, input logic [31:0] d);
    cp(1'h1, 3'h0, m, 3'h0, d, 1'h0);
  endtask
  task automatic cmd(input logic [2:0] o2);
    cp(1'h1, 3'h3, 4'h3, o2, 32'h0, 1'h0);
  endtask
  task automatic rdc(input logic [3:0] m);
    cp(1'h0, 3'h0, m, 3'h0, 32'h0, 1'h0);
  endtask
  // drain leftovers, program and start the selected channel
  task automatic go(input logic [31:0] c, ia, ea, input logic u);
    for (int n = 0; n < 40 && acc_valid !== 1'h0; n++) @(posedge clk_sys);
    got = {};
    cp(1'h1, 3'h0, 4'h4, 3'h0, c, u);
    wr(4'h5, ia);
    wr(4'h6, ea);
    cmd(3'h1);
  endtask
  task automatic run(input int cnt, input logic [31:0] ib, ii, eb, ei, input logic [5:0] f);
    for (int n = 0; n < 60 && got.size() < cnt; n++) @(posedge clk_sys);
    repeat (4) @(posedge clk_sys);
    for (int k = 0; k < cnt; k++) begin
      chk(got[k].int_addr, ib + ii * 32'(k));
      chk(got[k].ext_addr, eb + ei * 32'(k));
      chk({26'h0, got[k][69:64]}, {26'h0, f});
    end
  endtask
  initial begin
    repeat (3000) @(posedge clk_sys);
    bad_count++;
    print_verdict();
  end
  initial begin
    arst_n = 1'h0;
    cp_valid = 1'h0;
    cp_write = 1'h0;
    cp_opc1 = 3'h0;
    cp_opc2 = 3'h0;
    cp_crm = 4'h0;
    cp_wdata = 32'h0;
    cp_user_mode = 1'h0;
    chan_user_bit = 2'h2;
    stall = 1'h0;
    fault_now = 1'h0;
    end_addr = 32'h0;
    bad_count = 0;
    total_checks = 0;
    repeat (4) @(posedge clk_sys);
    arst_n <= 1'h1;
    rdc(4'h4);
    chk(rd, 32'h0800_0000);
    rdc(4'h7);
    chk(rd, 32'h0);
    wr(4'h4, 32'hffff_ffff);
    rdc(4'h4);
    chk(rd, 32'hfc0f_ff03);
    wr(4'h2, 32'h1);
    cp(1'h1, 3'h0, 4'h4, 3'h0, 32'h0, 1'h1);
    rdc(4'h4);
    chk(rd, 32'h0800_0000);
    wr(4'h2, 32'h0);
    rdc(4'h4);
    chk(rd, 32'hfc0f_ff03);
    end_addr <= 32'h108;
    stall <= 1'h1;
    go(32'h2008_0002, 32'h100, 32'h2000, 1'h0);
    repeat (12) @(posedge clk_sys);
    chk({31'h0, acc_valid}, 32'h1);
    wr(4'h4, 32'h0);
    rdc(4'h4);
    chk(rd, 32'h2808_0002);
    stall <= 1'h0;
    run(3, 32'h100, 32'h4, 32'h2000, 32'h800, 6'h02);
    chk({30'h0, dma_irq}, 32'h1);
    rdc(4'h8);
    chk(rd & 32'h13f, 32'h103);
    cmd(3'h2);
    rdc(4'h8);
    chk(rd & 32'h13f, 32'h0);
    chk({30'h0, dma_irq}, 32'h0);
    end_addr <= 32'h204;
    go(32'hc000_0001, 32'h200, 32'h3000, 1'h0);
    run(3, 32'h200, 32'h2, 32'h3000, 32'h0, 6'h19);
    chk({30'h0, dma_irq}, 32'h0);
    cmd(3'h2);
    wr(4'h2, 32'h1);
    fault_now <= 1'h1;
    go(32'h0, 32'h300, 32'h4000, 1'h1);
    run(1, 32'h300, 32'h1, 32'h4000, 32'h0, 6'h24);
    fault_now <= 1'h0;
    chk({30'h0, dma_irq}, 32'h2);
    rdc(4'h8);
    chk(rd & 32'h117, 32'h114);
    cmd(3'h2);
    chk({30'h0, dma_irq}, 32'h0);
    wr(4'h2, 32'h0);
    go(32'h1000_0301, 32'h400, 32'h5000, 1'h0);
    repeat (4) @(posedge clk_sys);
    rdc(4'h8);
    chk(rd & 32'h127, 32'h124);
    chk({30'h0, dma_irq}, 32'h1);
    cmd(3'h2);
    print_verdict();
  end
endmodule // tcm_dma_channel_control_tb_top
